/* spp_fifo.sv */
// file: parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module spp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic wr, rd;

  always_comb begin
    in_ready = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_next = wr ? ((wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next = rd ? ((rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
  end
  assign out_data = mem_reg[rp_reg];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* spp_pkg.sv */
// package: constants, encodings and carriers of the serial port packetizer
package spp_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int TICK_MS_NS = 1000000;
  localparam int CLK_NS = 5;
  localparam int CYC_PER_MS = TICK_MS_NS / CLK_NS;
  localparam int MS_PER_S = 1000;
  localparam int BUF_BYTES = 600;
  localparam int FIFO_DEPTH = 16;
  localparam int INACT_MAX_S = 3600;
  localparam int GAP_MAX_MS = 10000;
  localparam int GAP_MIN_MS = 10;

  typedef enum logic [2:0] {
    SPP_LT_RS232 = 3'h1, SPP_LT_485E = 3'h2, SPP_LT_485N = 3'h3, SPP_LT_RS422 = 3'h4
  } spp_line_e;
  typedef enum logic [1:0] {SPP_PAR_NONE = 2'h1, SPP_PAR_EVEN = 2'h2, SPP_PAR_ODD = 2'h3} spp_par_e;
  typedef enum logic [1:0] {SPP_DTR_HIGH = 2'h1, SPP_DTR_LOW = 2'h2, SPP_DTR_CONN = 2'h3} spp_dtr_e;
  typedef enum logic [1:0] {SPP_DSR_NONE = 2'h1, SPP_DSR_GATE = 2'h2, SPP_DSR_OPEN = 2'h3} spp_dsr_e;
  typedef enum logic [1:0] {
    SPP_HM_SERVER = 2'h0, SPP_HM_CLIENT = 2'h1, SPP_HM_UDP_SRV = 2'h2
  } spp_host_e;

  // divisor per baud code 1..9
  localparam logic [17:0] BAUD_DIV [1:9] = '{
    18'h28B0B, 18'h14585, 18'h0A2C3, 18'h05161, 18'h03641,
    18'h028B1, 18'h01458, 18'h00D90, 18'h006C8
  };
  localparam logic [3:0] BAUD_DEF = 4'h4;

  typedef struct packed {
    spp_line_e line;
    logic [3:0] baud;
    logic data7;
    spp_par_e parity;
    logic stop2;
    logic flow_hw;
    spp_dtr_e dtr;
    spp_dsr_e dsr;
    spp_host_e host;
    logic [11:0] inact_s;
    logic [13:0] gap_ms;
  } spp_cfg_s;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } spp_word_s;
endpackage

/* spp_port.sv */
// file: serial port uart, modem control, packing buffer and timers
`timescale 1ns/10ps
`default_nettype none
module spp_port #(
  parameter int CYC_MS = spp_pkg::CYC_PER_MS,
  parameter int BUF_SIZE = spp_pkg::BUF_BYTES,
  parameter int FIFO_DEPTH = spp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // configuration
  input wire spp_pkg::spp_cfg_s cfg,
  // serial line
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic rts,
  input wire logic cts,
  output logic dtr,
  input wire logic dsr,
  // network session side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic pkt_valid,
  input wire logic pkt_ready,
  output spp_pkg::spp_word_s pkt_word,
  input wire logic conn_up,
  input wire logic conn_req_in,
  output logic conn_accept,
  output logic conn_open_req,
  output logic conn_close_req,
  input wire logic probe_lost,
  input wire logic dgram_rx,
  output logic peer_bound,
  output logic echo_err,
  output logic rx_err
);
  localparam int DW = 18;
  spp_pkg::spp_cfg_s c;
  logic [DW-1:0] div;
  logic is232, flow_on, chr_evt;
  always_comb begin
    c = cfg;
    // a cleared configuration word reads as the 8N1 default
    if (cfg.parity == 2'h0) begin
      c.parity = spp_pkg::SPP_PAR_NONE;
    end
    div = spp_pkg::BAUD_DIV[(cfg.baud >= 4'h1 && cfg.baud <= 4'h9) ? cfg.baud
                            : spp_pkg::BAUD_DEF];
    is232 = (c.line == spp_pkg::SPP_LT_RS232);
    flow_on = is232 && c.flow_hw;
  end

  // ====================
  // transmitter
  logic [DW-1:0] tcnt_reg, tcnt_next;
  logic [3:0] tbit_reg, tbit_next;
  logic [11:0] tsh_reg, tsh_next;
  logic tbusy_reg, tbusy_next, txd_reg, txd_next;
  logic [7:0] tlast_reg, tlast_next;
  logic tdone;
  logic [3:0] nbits;
  logic par_bit;
  always_comb begin
    nbits = (c.data7 ? 4'd7 : 4'd8) + ((c.parity != spp_pkg::SPP_PAR_NONE) ? 4'd1 : 4'd0)
            + (c.stop2 ? 4'd2 : 4'd1);
    par_bit = (c.data7 ? ^tx_data[6:0] : ^tx_data) ^ (c.parity == spp_pkg::SPP_PAR_ODD);
    tx_ready = !tbusy_reg && (!flow_on || cts);
    tcnt_next = tcnt_reg;
    tbit_next = tbit_reg;
    tsh_next = tsh_reg;
    tbusy_next = tbusy_reg;
    txd_next = txd_reg;
    tlast_next = tlast_reg;
    tdone = 1'b0;
    if (!tbusy_reg) begin
      if (tx_valid && tx_ready) begin
        tbusy_next = 1'b1;
        tlast_next = c.data7 ? {1'b0, tx_data[6:0]} : tx_data;
        tcnt_next = div - 1'b1;
        tbit_next = nbits + 4'd1;
        txd_next = 1'b0;
        tsh_next = 12'hFFF;
        if (c.data7) begin
          tsh_next[6:0] = tx_data[6:0];
          tsh_next[7] = (c.parity != spp_pkg::SPP_PAR_NONE) ? par_bit : 1'b1;
        end else begin
          tsh_next[7:0] = tx_data;
          tsh_next[8] = (c.parity != spp_pkg::SPP_PAR_NONE) ? par_bit : 1'b1;
        end
      end
    end else if (tcnt_reg != '0) begin
      tcnt_next = tcnt_reg - 1'b1;
    end else if (tbit_reg == 4'd1) begin
      tbusy_next = 1'b0;
      tdone = 1'b1;
      txd_next = 1'b1;
    end else begin
      tcnt_next = div - 1'b1;
      tbit_next = tbit_reg - 1'b1;
      txd_next = tsh_reg[0];
      tsh_next = {1'b1, tsh_reg[11:1]};
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tcnt_reg <= '0;
      tbit_reg <= '0;
      tsh_reg <= 12'hFFF;
      tbusy_reg <= 1'b0;
      txd_reg <= 1'b1;
      tlast_reg <= '0;
    end else begin
      tcnt_reg <= tcnt_next;
      tbit_reg <= tbit_next;
      tsh_reg <= tsh_next;
      tbusy_reg <= tbusy_next;
      txd_reg <= txd_next;
      tlast_reg <= tlast_next;
    end
  end
  assign txd = txd_reg;
  // two-wire rs485 drives only while a frame is out; rs232/422 always drive
  assign txd_oe = is232 || (c.line == spp_pkg::SPP_LT_RS422) || tbusy_reg;

  // ====================
  // receiver
  logic [DW-1:0] rcnt_reg, rcnt_next;
  logic [3:0] rbit_reg, rbit_next;
  logic [10:0] rsh_reg, rsh_next;
  logic rbusy_reg, rbusy_next, rdone, rpar_ok;
  logic [7:0] rbyte;
  always_comb begin
    rcnt_next = rcnt_reg;
    rbit_next = rbit_reg;
    rsh_next = rsh_reg;
    rbusy_next = rbusy_reg;
    rdone = 1'b0;
    if (!rbusy_reg) begin
      if (!rxd) begin
        rbusy_next = 1'b1;
        rcnt_next = {1'b0, div[DW-1:1]};
        rbit_next = nbits - (c.stop2 ? 4'd1 : 4'd0) + 4'd1;
      end
    end else if (rcnt_reg != '0) begin
      rcnt_next = rcnt_reg - 1'b1;
    end else begin
      rcnt_next = div - 1'b1;
      rbit_next = rbit_reg - 1'b1;
      rsh_next = {rxd, rsh_reg[10:1]};
      if (rbit_reg == 4'd1) begin
        rbusy_next = 1'b0;
        rdone = 1'b1;
      end
    end
    // align sampled bits: last bit (stop) lands in rsh_next[10]
    rbyte = c.data7 ? {1'b0, rsh_next[11-nbits+(c.stop2 ? 4'd1 : 4'd0)+:7]}
                    : rsh_next[11-nbits+(c.stop2 ? 4'd1 : 4'd0)+:8];
    rpar_ok = (c.parity == spp_pkg::SPP_PAR_NONE) ||
              ((^rbyte ^ rsh_next[9] ^ (c.parity == spp_pkg::SPP_PAR_ODD)) == 1'b0);
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rcnt_reg <= '0;
      rbit_reg <= '0;
      rsh_reg <= '1;
      rbusy_reg <= 1'b0;
    end else begin
      rcnt_reg <= rcnt_next;
      rbit_reg <= rbit_next;
      rsh_reg <= rsh_next;
      rbusy_reg <= rbusy_next;
    end
  end

  // ====================
  // echo check, packing, gap and inactivity timers, modem control
  logic is_echo, is_485;
  logic [9:0] bcnt_reg, bcnt_next;
  logic [31:0] gap_reg, gap_next;
  logic [31:0] inms_reg, inms_next;
  logic [11:0] insec_reg, insec_next;
  logic echo_err_reg, echo_err_next, rx_err_reg, rx_err_next;
  logic bound_reg, bound_next, idle_close;
  logic f_valid, f_ready, hold_valid_reg, hold_valid_next;
  spp_pkg::spp_word_s hold_reg, hold_next;
  logic rx_store;
  always_comb begin
    is_echo = (c.line == spp_pkg::SPP_LT_485E);
    is_485 = is_echo || (c.line == spp_pkg::SPP_LT_485N);
    // own characters on the shared pair are compared (echo) or ignored, never packed
    rx_store = rdone && !(is_485 && tbusy_reg);
    echo_err_next = echo_err_reg | (rdone && is_echo && tbusy_reg && rbyte != tlast_reg);
    rx_err_next = rx_err_reg | (rdone && (!rpar_ok || !rsh_next[10]));
    chr_evt = rx_store || tdone;
    hold_next = hold_reg;
    // tail byte waits in the hold stage until the next byte comes, or the gap or a full buffer marks it last
    f_valid = hold_valid_reg && (hold_reg.last || rx_store);
    hold_valid_next = hold_valid_reg && !(f_valid && f_ready);
    bcnt_next = bcnt_reg;
    gap_next = gap_reg;
    if (rx_store && (!hold_valid_reg || (f_valid && f_ready))) begin
      hold_valid_next = 1'b1;
      hold_next.data = rbyte;
      hold_next.last = (bcnt_reg == 10'(BUF_SIZE - 1));
      bcnt_next = hold_next.last ? '0 : bcnt_reg + 1'b1;
      gap_next = '0;
    end else if (bcnt_reg == '0) begin
      gap_next = '0;
    end else if (gap_reg >= 32'(c.gap_ms) * 32'(CYC_MS)) begin
      hold_next.last = 1'b1;
      bcnt_next = '0;
      gap_next = '0;
    end else begin
      gap_next = gap_reg + 1'b1;
    end
    // inactivity: one-second cycle prescale, then seconds
    inms_next = inms_reg;
    insec_next = insec_reg;
    idle_close = 1'b0;
    if (chr_evt || !conn_up || c.inact_s == '0) begin
      inms_next = '0;
      insec_next = '0;
    end else if (inms_reg == 32'(CYC_MS * spp_pkg::MS_PER_S - 1)) begin
      inms_next = '0;
      insec_next = insec_reg + 1'b1;
    end else begin
      inms_next = inms_reg + 1'b1;
    end
    if (conn_up && c.inact_s != '0 && insec_reg >= c.inact_s) begin
      idle_close = 1'b1;
    end
    bound_next = bound_reg | (c.host == spp_pkg::SPP_HM_UDP_SRV && c.inact_s == '0
                              && dgram_rx);
  end
  always_comb begin
    rts = flow_on ? f_ready : 1'b1;
    // dtr is only ever driven, dsr only sampled
    case (c.dtr)
      spp_pkg::SPP_DTR_HIGH: dtr = 1'b1;
      spp_pkg::SPP_DTR_LOW: dtr = 1'b0;
      spp_pkg::SPP_DTR_CONN: dtr = conn_up;
      default: dtr = 1'b1;
    endcase
    conn_accept = conn_req_in && (c.host != spp_pkg::SPP_HM_CLIENT) &&
                  (c.dsr != spp_pkg::SPP_DSR_GATE || dsr);
    conn_open_req = (c.host == spp_pkg::SPP_HM_CLIENT) && (c.dsr == spp_pkg::SPP_DSR_OPEN)
                    && dsr && !conn_up;
    conn_close_req = conn_up && (idle_close || (probe_lost && c.host != spp_pkg::SPP_HM_UDP_SRV)
                     || ((c.host == spp_pkg::SPP_HM_CLIENT) && (c.dsr == spp_pkg::SPP_DSR_OPEN)
                     && !dsr));
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bcnt_reg <= '0;
      gap_reg <= '0;
      inms_reg <= '0;
      insec_reg <= '0;
      echo_err_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      bound_reg <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      bcnt_reg <= bcnt_next;
      gap_reg <= gap_next;
      inms_reg <= inms_next;
      insec_reg <= insec_next;
      echo_err_reg <= echo_err_next;
      rx_err_reg <= rx_err_next;
      bound_reg <= bound_next;
      hold_valid_reg <= hold_valid_next;
      hold_reg <= hold_next;
    end
  end
  assign echo_err = echo_err_reg;
  assign rx_err = rx_err_reg;
  assign peer_bound = bound_reg;

  spp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(hold_reg),
    .out_valid(pkt_valid),
    .out_ready(pkt_ready),
    .out_data(pkt_word)
  );

  // ====================
  // checks
  property p_dtr_policy;
    @(posedge clk_sys) disable iff (!reset_n)
      c.dtr == spp_pkg::SPP_DTR_CONN |-> dtr == conn_up;
  endproperty
  a_dtr_policy: assert property (p_dtr_policy) else $error("dtr not tracking connection");
  property p_flow_off;
    @(posedge clk_sys) disable iff (!reset_n) !is232 |-> rts;
  endproperty
  a_flow_off: assert property (p_flow_off) else $error("rts paced outside rs232");
  property p_cts_hold;
    @(posedge clk_sys) disable iff (!reset_n) flow_on && !cts |-> !tx_ready;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("sent while cts low");
  property p_gate;
    @(posedge clk_sys) disable iff (!reset_n) conn_accept && c.dsr == spp_pkg::SPP_DSR_GATE |-> dsr;
  endproperty
  a_gate: assert property (p_gate) else $error("accepted with dsr low");
  property p_open;
    @(posedge clk_sys) disable iff (!reset_n) conn_open_req |-> dsr && !conn_up;
  endproperty
  a_open: assert property (p_open) else $error("open request without dsr");
  property p_gap_idle;
    @(posedge clk_sys) disable iff (!reset_n) bcnt_reg == '0 |=> gap_reg == '0;
  endproperty
  a_gap_idle: assert property (p_gap_idle) else $error("gap counting while empty");
  property p_bound;
    @(posedge clk_sys) disable iff (!reset_n) bound_reg |=> bound_reg;
  endproperty
  a_bound: assert property (p_bound) else $error("peer binding lost");
  sequence s_txstart;
    tx_valid && tx_ready;
  endsequence
  property p_startbit;
    @(posedge clk_sys) disable iff (!reset_n) s_txstart |=> !txd && tbusy_reg;
  endproperty
  a_startbit: assert property (p_startbit) else $error("no start bit");
endmodule
`default_nettype wire

/* spp_serial_dev.sv */
// behavioural serial device on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module spp_serial_dev #(
  parameter int BIT_CYC = 1736
) (
  // clock
  input wire logic clk_sys,
  // serial wires
  input wire logic line_in,
  output var logic line_out,
  output var logic cts
);
  logic [11:0] got_q[$];
  logic [11:0] raw;

  // ==========================================================
  // receiver: start bit and the eleven bits after it (frame plus idle), mid-bit sampled
  initial begin
    line_out = 1'b1;
    cts = 1'b1;
    forever begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 12; i++) begin
        raw[i] = line_in;
        if (i < 11) begin
          repeat (BIT_CYC) @(posedge clk_sys);
        end
      end
      got_q.push_back(raw);
    end
  end

  // ==========================================================
  // sender: 8 data bits, no parity, one stop bit
  // frames go back to back, so gaps stay below any sane timeout
  task automatic send(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      line_out = fr[i];
      repeat (BIT_CYC - 1) @(negedge clk_sys);
    end
  endtask

  // low cts holds the port off on an rs232 line with flow_hw set, the slow answer of this device
  task automatic set_cts(input logic v);
    cts = v;
  endtask
endmodule
`default_nettype wire

/* tb_spp_port.sv */
// testbench of the serial port packetizer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_spp_port;
  localparam int CMS = 5;
  localparam int BITC = spp_pkg::BAUD_DIV[9];
  // one hex digit a field
  typedef struct packed {
    logic [3:0] line;
    logic [3:0] flow;
    logic [3:0] dtr;
    logic [3:0] dsr;
    logic [3:0] host;
    logic [3:0] up;
    logic [3:0] dsr_in;
    logic [3:0] cts;
    logic [3:0] req;
    logic [3:0] probe;
    logic [3:0] sel;
    logic [3:0] ex;
  } spp_row_s;
  // sel: 0 dtr, 1 tx_ready, 2 accept, 3 open, 4 close, 5 rts
  localparam spp_row_s ROWS [19] = '{
    48'h1011_0000_0011, 48'h1111_0000_0010, 48'h1111_0001_0011, 48'h4111_0000_0011,
    48'h3111_0000_0051, 48'h1111_0000_0051, 48'h1011_0000_0001, 48'h1021_0100_0000,
    48'h1031_0000_0000, 48'h1031_0100_0001, 48'h1012_0000_1020, 48'h1012_0010_1021,
    48'h1011_0000_1021, 48'h1013_1010_0031, 48'h1013_1000_0030, 48'h1013_1100_0041,
    48'h1013_1110_0040, 48'h1011_0100_0141, 48'h1011_0100_0040
  };
  logic clk_sys, reset_n, txd, txd_oe, rts, cts, dtr, dsr, rxd_w, dev_out, mdl_in, is485;
  logic tx_valid, tx_ready, pkt_valid, pkt_ready, conn_up, conn_req_in, conn_accept;
  logic conn_open_req, conn_close_req, probe_lost, dgram_rx, peer_bound, echo_err, rx_err;
  logic [7:0] tx_data;
  logic [5:0] outs;
  logic [11:0] got;
  spp_pkg::spp_cfg_s cfg;
  spp_pkg::spp_word_s pkt_word;
  spp_pkg::spp_word_s w [2];
  spp_row_s r;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  // ==========================================================
  // shared two-wire line in the RS485 types, separate wires otherwise
  assign is485 = cfg.line == spp_pkg::SPP_LT_485E || cfg.line == spp_pkg::SPP_LT_485N;
  assign rxd_w = (is485 && txd_oe) ? txd : dev_out;
  assign mdl_in = is485 ? rxd_w : txd;
  assign outs = {rts, conn_close_req, conn_open_req, conn_accept, tx_ready, dtr};

  spp_port #(.CYC_MS(CMS)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg), .rxd(rxd_w), .txd(txd),
    .txd_oe(txd_oe), .rts(rts), .cts(cts), .dtr(dtr), .dsr(dsr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_word(pkt_word), .conn_up(conn_up), .conn_req_in(conn_req_in),
    .conn_accept(conn_accept), .conn_open_req(conn_open_req),
    .conn_close_req(conn_close_req), .probe_lost(probe_lost), .dgram_rx(dgram_rx),
    .peer_bound(peer_bound), .echo_err(echo_err), .rx_err(rx_err)
  );
  spp_serial_dev #(.BIT_CYC(BITC)) u_dev (
    .clk_sys(clk_sys), .line_in(mdl_in), .line_out(dev_out), .cts(cts)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic base();
    cfg = '0;
    cfg.line = spp_pkg::SPP_LT_RS232;
    cfg.baud = 4'h9;
    cfg.dtr = spp_pkg::SPP_DTR_HIGH;
    cfg.dsr = spp_pkg::SPP_DSR_NONE;
    cfg.host = spp_pkg::SPP_HM_SERVER;
    cfg.gap_ms = 14'h0FA0;
    conn_up = 1'b0;
    dsr = 1'b0;
    conn_req_in = 1'b0;
    probe_lost = 1'b0;
    u_dev.set_cts(1'b1);
  endtask

  // valid held until an edge that sees ready high
  task automatic send_tx(input logic [7:0] d);
    @(negedge clk_sys);
    tx_valid = 1'b1;
    tx_data = d;
    for (n = 0; n < 100 && tx_ready !== 1'b1; n++) @(negedge clk_sys);
    @(posedge clk_sys);
    @(negedge clk_sys);
    tx_valid = 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    pkt_ready = 1'b0;
    dgram_rx = 1'b0;
    base();
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    `CHK("txd idle", 1'b1, txd)
    `CHK("pkt_valid", 1'b0, pkt_valid)
    `CHK("sticky flags", 3'h0, {echo_err, rx_err, peer_bound})
    end_test("reset");

    for (int k = 0; k < 19; k++) begin
      r = ROWS[k];
      @(negedge clk_sys);
      cfg.line = spp_pkg::spp_line_e'(r.line[2:0]);
      cfg.flow_hw = r.flow[0];
      cfg.dtr = spp_pkg::spp_dtr_e'(r.dtr[1:0]);
      cfg.dsr = spp_pkg::spp_dsr_e'(r.dsr[1:0]);
      cfg.host = spp_pkg::spp_host_e'(r.host[1:0]);
      conn_up = r.up[0];
      dsr = r.dsr_in[0];
      u_dev.set_cts(r.cts[0]);
      conn_req_in = r.req[0];
      probe_lost = r.probe[0];
      repeat (2) @(negedge clk_sys);
      `CHK("row output", r.ex[0], outs[r.sel[2:0]])
    end
    end_test("table");

    // echo type, 7E2, top data bit must be dropped, cts low ignored
    base();
    cfg.line = spp_pkg::SPP_LT_485E;
    cfg.data7 = 1'b1;
    cfg.parity = spp_pkg::SPP_PAR_EVEN;
    cfg.stop2 = 1'b1;
    cfg.flow_hw = 1'b1;
    u_dev.set_cts(1'b0);
    send_tx(8'h93);
    repeat (3 * BITC) @(negedge clk_sys);
    `CHK("txd_oe in frame", 1'b1, txd_oe)
    for (n = 0; n < 30000 && u_dev.got_q.size() == 0; n++) @(negedge clk_sys);
    got = (u_dev.got_q.size() > 0) ? u_dev.got_q.pop_front() : 12'h000;
    `CHK("tx frame", 12'hF26, got)
    `CHK("txd_oe after", 1'b0, txd_oe)
    `CHK("echo_err", 1'b0, echo_err)
    `CHK("echo not packed", 1'b0, pkt_valid)
    end_test("transmit");

    base();
    cfg.inact_s = 12'h001;
    cfg.gap_ms = 14'h0064;
    conn_up = 1'b1;
    repeat (4000) @(negedge clk_sys);
    `CHK("close early", 1'b0, conn_close_req)
    for (n = 0; n < 2000 && conn_close_req !== 1'b1; n++) @(negedge clk_sys);
    `CHK("idle close", 1'b1, conn_close_req)
    end_test("inactivity");

    base();
    cfg.host = spp_pkg::SPP_HM_UDP_SRV;
    @(negedge clk_sys);
    dgram_rx = 1'b1;
    @(negedge clk_sys);
    dgram_rx = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("peer bound", 1'b1, peer_bound)
    end_test("bind");

    // own no-echo frame first: it must not be packed ahead of the received bytes
    base();
    cfg.line = spp_pkg::SPP_LT_485N;
    send_tx(8'h5A);
    for (n = 0; n < 20000 && txd_oe !== 1'b0; n++) @(negedge clk_sys);
    cfg.line = spp_pkg::SPP_LT_RS232;
    // network side stalls while two bytes arrive, then drains
    u_dev.send(8'hA5);
    u_dev.send(8'h3C);
    repeat (1000) @(negedge clk_sys);
    `CHK("word waiting", 1'b1, pkt_valid)
    `CHK("held word", 9'h0A5, pkt_word)
    repeat (19500) @(negedge clk_sys);
    pkt_ready = 1'b1;
    for (int i = 0; i < 2; i++) begin
      for (n = 0; n < 100 && pkt_valid !== 1'b1; n++) @(negedge clk_sys);
      w[i] = pkt_word;
      @(negedge clk_sys);
    end
    pkt_ready = 1'b0;
    `CHK("first word", 9'h0A5, w[0])
    `CHK("last word", 9'h13C, w[1])
    `CHK("drained", 1'b0, pkt_valid)
    `CHK("rx_err", 1'b0, rx_err)
    got = (u_dev.got_q.size() > 0) ? u_dev.got_q.pop_front() : 12'h000;
    `CHK("no-echo tx frame", 12'hEB4, got)
    `CHK("peer kept", 1'b1, peer_bound)
    end_test("receive");
    give_verdict();
  end
endmodule
`default_nettype wire
